// ### design/bpsc_pkg.sv
package bpsc_pkg;
  // ***************************************************************
  // register offset (byte address of the dword in config space)
  // ***************************************************************
  localparam logic [7:0] PM_CTRL_STAT_OFFSET = 8'h84;
  localparam logic [31:0] PM_CTRL_STAT_RESET = 32'h0000_0000;
  // field positions
  localparam int PS_LSB = 0;
  localparam int PS_MSB = 1;
  localparam int NSR_BIT = 3;
  localparam int WAKE_EN_BIT = 8;
  localparam int POWER_DATA_SELECT_LSB = 9;
  localparam int POWER_DATA_SELECT_MSB = 12;
  localparam int POWER_DATA_SCALE_LSB = 13;
  localparam int POWER_DATA_SCALE_MSB = 14;
  localparam int WAKE_STAT_BIT = 15;
  localparam logic [1:0] PS_RESET = 2'h0;
  localparam logic WAKE_EN_RESET = 1'b0;
  // ***************************************************************
  // power states
  // ***************************************************************
  typedef enum logic [1:0] {
    BPSC_D0 = 2'b00,
    BPSC_D1 = 2'b01,
    BPSC_D2 = 2'b10,
    BPSC_D3 = 2'b11
  } bpsc_pstate_e;
  // downstream cycle kinds
  typedef enum logic [1:0] {
    BPSC_CYC_CFG0 = 2'b00,
    BPSC_CYC_CFG1 = 2'b01,
    BPSC_CYC_MEM = 2'b10,
    BPSC_CYC_IO = 2'b11
  } bpsc_cyc_e;
  // cycles the soft-reset pulse is held
  localparam int SOFT_RST_CYCLES = 4;
  localparam logic [2:0] SOFT_RST_LEN = 3'(SOFT_RST_CYCLES);
endpackage : bpsc_pkg

// ### design/bpsc_state_reg.sv
// ***************************************************************
// power state holder: drops unsupported encodings
// ***************************************************************
module bpsc_state_reg
  import bpsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [1:0] wrState,
  output bpsc_pkg::bpsc_pstate_e state_q,
  output logic wakeD0_q
);
  import bpsc_pkg::*;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= BPSC_D0;
      wakeD0_q <= 1'b0;
    end else if (clkEn) begin
      wakeD0_q <= 1'b0;
      if (wrEn && (wrState == BPSC_D0 || wrState == BPSC_D3)) begin
        state_q <= bpsc_pstate_e'(wrState);
        wakeD0_q <= (state_q == BPSC_D3) && (wrState == BPSC_D0);
      end
    end
  end

  a_drop_unsupported: assert property (
    @(posedge ref_clk) disable iff (reset)
    !reset && clkEn && wrEn && (wrState == 2'b01 || wrState == 2'b10)
    |=> $stable(state_q))
    else $error("unsupported power state was stored");
endmodule : bpsc_state_reg

// ### design/bpsc_power_ctrl.sv
module bpsc_power_ctrl
  import bpsc_pkg::*;
#(
  parameter int RstCycles = SOFT_RST_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  input wire logic [3:0] cfgByteEn,
  output logic [31:0] cfgRdData_q,
  output logic cfgDone_q,
  input wire logic dsCycValid,
  input wire logic [1:0] dsCycKind,
  output logic dsClaim_q,
  output logic dsAbort_q,
  input wire logic intReq,
  output logic intOut_q,
  input wire logic mmrReq,
  output logic mmrAccept_q,
  output logic [1:0] powerState_q,
  output logic ctxReset_q
);
  import bpsc_pkg::*;

  // the pulse counter is three bits wide, so 7 cycles is the longest pulse
  if (RstCycles < 1 || RstCycles > 7) begin : g_bad_len
    $error("soft reset length must be 1 to 7 cycles");
  end
  localparam logic [2:0] RstLen = 3'(RstCycles);

  // ***************************************************************
  // register write decode
  // ***************************************************************
  logic hitReg;
  logic psWrite;
  bpsc_pstate_e state;
  logic wakeD0;
  logic wakeEn_q;
  logic [2:0] rstCnt_q;

  assign hitReg = cfgAddr[7:2] == PM_CTRL_STAT_OFFSET[7:2];
  assign psWrite = cfgWrEn && hitReg && cfgByteEn[0];

  bpsc_state_reg u_state (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkEn(clkEn),
    .wrEn(psWrite),
    .wrState(cfgWrData[PS_MSB:PS_LSB]),
    .state_q(state),
    .wakeD0_q(wakeD0)
  );

  // sticky bit: only platform reset clears it, not the soft reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wakeEn_q <= WAKE_EN_RESET;
    end else if (clkEn && cfgWrEn && hitReg && cfgByteEn[1]) begin
      wakeEn_q <= cfgWrData[WAKE_EN_BIT];
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  function automatic logic [31:0] pmReadWord(input logic [1:0] ps,
                                             input logic we);
    logic [31:0] w;
    w = PM_CTRL_STAT_RESET;
    w[PS_MSB:PS_LSB] = ps;
    w[WAKE_EN_BIT] = we;
    return w;
  endfunction : pmReadWord

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfgRdData_q <= 32'h0;
      cfgDone_q <= 1'b0;
    end else if (clkEn) begin
      // config accesses complete whenever clkEn is high, even in D3
      cfgDone_q <= cfgWrEn || cfgRdEn;
      if (cfgRdEn && hitReg) begin
        cfgRdData_q <= pmReadWord(state, wakeEn_q);
      end else begin
        cfgRdData_q <= 32'h0;
      end
    end
  end

  // ***************************************************************
  // internal context reset after software D3 to D0
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rstCnt_q <= 3'h0;
      ctxReset_q <= 1'b0;
    end else if (clkEn) begin
      if (wakeD0) begin
        rstCnt_q <= RstLen;
        ctxReset_q <= 1'b1;
      end else if (rstCnt_q > 3'h1) begin
        rstCnt_q <= rstCnt_q - 3'h1;
      end else begin
        rstCnt_q <= 3'h0;
        ctxReset_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // claiming and gating
  // ***************************************************************
  // type 0 config stays open so software can still wake the bridge
  function automatic logic mayClaim(input bpsc_pstate_e ps,
                                    input logic [1:0] kind);
    return ps == BPSC_D0 || kind == BPSC_CYC_CFG0;
  endfunction : mayClaim

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dsClaim_q <= 1'b0;
      dsAbort_q <= 1'b0;
      intOut_q <= 1'b0;
      mmrAccept_q <= 1'b0;
      powerState_q <= PS_RESET;
    end else if (clkEn) begin
      powerState_q <= state;
      if (dsCycValid && mayClaim(state, dsCycKind)) begin
        dsClaim_q <= 1'b1;
        dsAbort_q <= 1'b0;
      end else begin
        dsClaim_q <= 1'b0;
        // the upstream side turns this into an unsupported request
        dsAbort_q <= dsCycValid;
      end
      // masked, not queued: a request made in D3 is simply lost
      intOut_q <= intReq && state == BPSC_D0;
      mmrAccept_q <= mmrReq && state == BPSC_D0;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_abort_outside_d0: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && dsCycValid && state != BPSC_D0 && dsCycKind != BPSC_CYC_CFG0
    |=> dsAbort_q && !dsClaim_q)
    else $error("cycle claimed outside D0");
  a_cfg0_claimed: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && dsCycValid && dsCycKind == BPSC_CYC_CFG0 |=> dsClaim_q)
    else $error("type 0 config cycle not claimed");
  a_no_int_d3: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && state == BPSC_D3 |=> !intOut_q)
    else $error("interrupt raised in D3");
  a_no_mmr_d3: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && state == BPSC_D3 |=> !mmrAccept_q)
    else $error("mmr cycle accepted in D3");
  a_read_fixed: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && cfgRdEn && hitReg |=> (cfgRdData_q & 32'hffff_fefc) == 32'h0)
    else $error("fixed field read nonzero");
  a_wake_sticky: assert property (
    @(posedge ref_clk) disable iff (reset)
    !reset && !(clkEn && cfgWrEn && hitReg && cfgByteEn[1])
    |=> $stable(wakeEn_q))
    else $error("wake enable changed without write");
  a_soft_reset: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && wakeD0 |=> ctxReset_q)
    else $error("no context reset after D3 to D0");
  a_reset_d0: assert property (
    @(posedge ref_clk)
    reset |=> state == BPSC_D0 && !wakeEn_q && !ctxReset_q)
    else $error("reset did not return to D0");
  a_cfg_done: assert property (
    @(posedge ref_clk) disable iff (reset)
    clkEn && cfgWrEn |=> cfgDone_q)
    else $error("config write not completed");
  a_ps_follows: assert property (
    @(posedge ref_clk) disable iff (reset)
    !reset && clkEn |=> powerState_q == $past(state))
    else $error("reported power state lags the held state");
  a_d0_claims_all: assert property (
    @(posedge ref_clk) disable iff (reset)
    !reset && clkEn && dsCycValid && state == BPSC_D0 |=> dsClaim_q)
    else $error("cycle not claimed in D0");
  a_mmr_d0: assert property (
    @(posedge ref_clk) disable iff (reset)
    !reset && clkEn && mmrReq && state == BPSC_D0 |=> mmrAccept_q)
    else $error("mmr cycle refused in D0");

  c_enter_d3: cover property (@(posedge ref_clk) state == BPSC_D3);
  c_soft_reset: cover property (@(posedge ref_clk) ctxReset_q);
  c_abort: cover property (@(posedge ref_clk) dsAbort_q);
  c_cfg0_d3: cover property (@(posedge ref_clk)
    dsClaim_q && state == BPSC_D3);
  c_freeze: cover property (@(posedge ref_clk)
    !clkEn && cfgWrEn);
endmodule : bpsc_power_ctrl

// ### testbench/bpsc_host_model.sv
// ***************************************************************
// upstream status: logs unclaimed downstream cycles
// ***************************************************************
module bpsc_host_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic dsAbort_q,
  output logic [15:0] hostBridgeStatus_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // sticky until reset, as software clears it in the real host
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hostBridgeStatus_q <= 16'h0000;
    end else if (dsAbort_q) begin
      hostBridgeStatus_q[13] <= 1'b1;
    end
  end
endmodule : bpsc_host_model

// ### testbench/bridge_power_state_control_tb.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module bridge_power_state_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bpsc_pkg::*;
  logic refClk, reset, clkEn, cfgWrEn, cfgRdEn, dsCycValid, intReq, mmrReq;
  logic [7:0] cfgAddr;
  logic [31:0] cfgWrData, cfgRdData_q, rd;
  logic [3:0] cfgByteEn;
  logic [1:0] dsCycKind, powerState_q;
  logic cfgDone_q, dsClaim_q, dsAbort_q, intOut_q, mmrAccept_q, ctxReset_q;
  logic [15:0] hostStat;
  int errors = 0, checks_done = 0, cycles = 0, n;
  bpsc_power_ctrl bpsc_power_ctrl_i (.ref_clk(refClk), .reset(reset),
    .clkEn(clkEn), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn), .cfgRdData_q(cfgRdData_q),
    .cfgDone_q(cfgDone_q), .dsCycValid(dsCycValid), .dsCycKind(dsCycKind),
    .dsClaim_q(dsClaim_q), .dsAbort_q(dsAbort_q), .intReq(intReq),
    .intOut_q(intOut_q), .mmrReq(mmrReq), .mmrAccept_q(mmrAccept_q),
    .powerState_q(powerState_q), .ctxReset_q(ctxReset_q));
  bpsc_host_model bpsc_host_model_i (.ref_clk(refClk), .reset(reset),
    .dsAbort_q(dsAbort_q), .hostBridgeStatus_q(hostStat));
  initial begin
    refClk = 1'b0;
    forever #2 refClk = ~refClk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ***************************************************************
  // access tasks
  // ***************************************************************
  task automatic cfg(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] be);
    @(posedge refClk);
    cfgWrEn <= wr;
    cfgRdEn <= !wr;
    cfgAddr <= a;
    cfgWrData <= d;
    cfgByteEn <= be;
    @(posedge refClk);
    cfgWrEn <= 1'b0;
    cfgRdEn <= 1'b0;
    #1;
    `CHK(cfgDone_q, 1'b1)
    rd = cfgRdData_q;
  endtask : cfg
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK(rd, exp)
  endtask : rdChk
  // presents one cycle of every kind with interrupt and mmr requests
  task automatic probeAll(input logic d0);
    for (int k = 0; k < 4; k++) begin
      @(posedge refClk);
      dsCycValid <= 1'b1;
      dsCycKind <= 2'(k);
      intReq <= 1'b1;
      mmrReq <= 1'b1;
      @(posedge refClk);
      dsCycValid <= 1'b0;
      intReq <= 1'b0;
      mmrReq <= 1'b0;
      #1;
      `CHK(dsClaim_q, d0 || k == 0)
      `CHK(dsAbort_q, !(d0 || k == 0))
      `CHK(intOut_q, d0)
      `CHK(mmrAccept_q, d0)
    end
  endtask : probeAll
  always @(posedge refClk) begin
    cycles++;
    if (cycles >= 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    {reset, clkEn, cfgWrEn, cfgRdEn, dsCycValid, intReq, mmrReq} <= 7'h60;
    {cfgAddr, cfgWrData, cfgByteEn, dsCycKind} <= '0;
    repeat (2) @(posedge refClk);
    reset <= 1'b0;
    rdChk(PM_CTRL_STAT_OFFSET, PM_CTRL_STAT_RESET);
    probeAll(1'b1);
    `CHK(hostStat[13], 1'b0)
    // a write while the clock enable is low must leave no trace
    @(posedge refClk);
    clkEn <= 1'b0;
    cfgWrEn <= 1'b1;
    cfgAddr <= PM_CTRL_STAT_OFFSET;
    cfgWrData <= 32'h0000_0103;
    cfgByteEn <= 4'hf;
    @(posedge refClk);
    cfgWrEn <= 1'b0;
    clkEn <= 1'b1;
    #1;
    `CHK(cfgDone_q, 1'b0)
    `CHK(powerState_q, 2'b00)
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0000);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'h0000_0001, 4'hf);
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0000);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'hffff_ffff, 4'h0);
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0000);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'hffff_ffff, 4'hf);
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0103);
    `CHK(powerState_q, 2'b11)
    probeAll(1'b0);
    `CHK(hostStat[13], 1'b1)
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'h0000_0002, 4'h1);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'h0000_0001, 4'h1);
    rdChk(8'h88, 32'h0000_0000);
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0103);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'h0000_0000, 4'h1);
    n = 0;
    repeat (8) begin
      @(posedge refClk);
      #1;
      n += ctxReset_q;
    end
    `CHK(n, SOFT_RST_CYCLES)
    rdChk(PM_CTRL_STAT_OFFSET, 32'h0000_0100);
    probeAll(1'b1);
    cfg(1'b1, PM_CTRL_STAT_OFFSET, 32'h0000_0003, 4'h1);
    @(posedge refClk);
    reset <= 1'b1;
    @(posedge refClk);
    reset <= 1'b0;
    #1;
    `CHK(powerState_q, 2'b00)
    `CHK(ctxReset_q, 1'b0)
    rdChk(PM_CTRL_STAT_OFFSET, PM_CTRL_STAT_RESET);
    `CHK(ctxReset_q, 1'b0)
    tally_and_finish();
  end
endmodule : bridge_power_state_control_tb
